// >>> rtl/cad_pkg.sv
// Constants and types for the core addressing decoder
// Overview of operation
// - One-instruction bit set/clear; carry takes old bit
// - Six-entry 12-bit return stack, calls and interrupts
// - Data space holds accumulator, pointers, registers, RAM
// - Immediate operand is the next program byte
// - Direct mode: next byte is data address
// - Short direct: opcode picks 80h..83h register
// - Extended: opcode low nibble joins next byte
// - Relative branches reach -15 to +16
// - Relative opcode: test, direction, 4-bit magnitude
// - False condition falls through to next instruction
// - Bit direct: opcode bit, next byte address
// - Bit test branch: three bytes, 8-bit displacement
// - Indirect: opcode bit 4 picks pointer 80h/81h
// - Inherent instructions are one byte
// - Opcodes sorted into five instruction groups
// - Load/store one to three bytes, accumulator operand
// - Immediate-to-register load bypasses the accumulator
// - Load/store four cycles; zero flag except immediate-to-register, carry kept
`default_nettype none
package cad_pkg;
    // Widths
    localparam int PC_W   = 12;            // Program address width
    localparam int SP_W   = 3;             // Stack index width
    localparam int SP_MAX = 8;             // Largest depth SP_W serves
    localparam logic [PC_W-1:0] RESET_PC = 12'h000; // Start address
    localparam logic [PC_W-1:0] PC_ONE   = 12'h001; // Address step
    // Data space map
    localparam logic [7:0] SHORT_BASE = 8'h80;  // Four short registers
    localparam logic [7:0] PTR_BASE   = 8'h80;  // Pointer pair base
    localparam logic [7:0] ACC_ADDR   = 8'hff;  // Accumulator location
    // Opcode classes, bits 7:5
    localparam logic [2:0] CLS_EXT  = 3'h4;     // Far branch and call
    localparam logic [2:0] CLS_BIT  = 3'h5;     // Bit direct and bit test
    localparam logic [2:0] CLS_LOAD = 3'h6;     // Load and store
    localparam logic [2:0] CLS_INH  = 3'h7;     // Inherent control
    // Load modes, bits 3:2
    localparam logic [1:0] LM_SHORT = 2'h0;     // Short direct
    localparam logic [1:0] LM_DIR   = 2'h1;     // Direct
    localparam logic [1:0] LM_IND   = 2'h2;     // Indirect
    localparam logic [1:0] LM_IMM   = 2'h3;     // Immediate
    // Inherent operations, bits 4:0
    localparam logic [4:0] INH_RET  = 5'h01;    // Return from call
    // Byte counts
    localparam logic [1:0] LEN_ONE   = 2'h1;    // One byte
    localparam logic [1:0] LEN_TWO   = 2'h2;    // Two bytes
    localparam logic [1:0] LEN_THREE = 2'h3;    // Three bytes
    // Cycle counts per instruction kind
    localparam logic [2:0] CYC_LDST = 3'h4;     // Load and store
    localparam logic [2:0] CYC_REL  = 3'h2;     // Relative branch
    localparam logic [2:0] CYC_BTB  = 3'h5;     // Bit test and branch
    localparam logic [2:0] CYC_BIT  = 3'h4;     // Bit set or clear
    localparam logic [2:0] CYC_EXT  = 3'h4;     // Far branch and call
    localparam logic [2:0] CYC_INH  = 3'h2;     // Inherent control
    // Instruction groups
    localparam logic [2:0] GRP_LDST   = 3'h0;   // Load and store
    localparam logic [2:0] GRP_BRANCH = 3'h2;   // Conditional branch
    localparam logic [2:0] GRP_CTRL   = 3'h3;   // Control
    localparam logic [2:0] GRP_JUMP   = 3'h4;   // Jump and call
    localparam logic [2:0] GRP_BITOP  = 3'h5;   // Bit manipulation
    // Sequencer states, Gray along the usual path
    typedef enum logic [2:0] {
        S_FETCH = 3'b000,
        S_B2    = 3'b001,
        S_B3    = 3'b011,
        S_DATA  = 3'b010,
        S_EXEC  = 3'b110,
        S_PAD   = 3'b111,
        S_PTR   = 3'b100
    } cad_state_t;
endpackage
`default_nettype wire

// >>> rtl/cad_decoder.sv
// Instruction decode, operand addressing and sequencing of the core
`timescale 1ns/1ps
`default_nettype none
module cad_decoder #(
    parameter int                      STACK_DEPTH = 6,       // Stack levels
    parameter logic [cad_pkg::PC_W-1:0] INT_VEC    = 12'h010  // Int target
) (
    input  wire logic                     clk_i,        // Core clock
    input  wire logic                     sys_rst_i,    // Sync reset
    input  wire logic [7:0]               prog_data_i,  // Program byte
    input  wire logic [7:0]               data_rdata_i, // Data read byte
    input  wire logic                     int_req_i,    // Interrupt level
    output logic [cad_pkg::PC_W-1:0]      prog_addr_o,  // Program address
    output logic [7:0]                    data_addr_o,  // Data address
    output logic                          data_rd_o,    // Data read strobe
    output logic                          data_we_o,    // Data write pulse
    output logic [7:0]                    data_wdata_o, // Data write byte
    output logic [7:0]                    acc_o,        // Accumulator
    output logic                          zero_o,       // Zero flag
    output logic                          carry_o,      // Carry flag
    output logic                          instr_done_o, // Instruction end
    output logic                          int_ack_o,    // Interrupt taken
    output logic [2:0]                    grp_o         // Current group
);
    import cad_pkg::*;

    // Refuse stack depths the index cannot hold
    if (STACK_DEPTH < 1 || STACK_DEPTH > SP_MAX) begin : g_bad_depth
        $error("cad_decoder: STACK_DEPTH out of range");
    end

    ////////////////////////////////////////////////////////////////////////
    // State
    cad_state_t       st_reg, st_next;          // Sequencer
    logic [PC_W-1:0]  pc_reg, pc_next;          // Program counter
    logic [PC_W-1:0]  ia_reg;                   // Address of opcode
    logic [7:0]       op_reg, b2_reg, b3_reg;   // Instruction bytes
    logic [7:0]       opnd_reg;                 // Data operand
    logic [7:0]       acc_reg, acc_next;        // Accumulator
    logic [7:0]       addr_reg, addr_next;      // Data address
    logic [7:0]       wdata_reg;                // Write byte
    logic             z_reg, z_next;            // Zero flag
    logic             c_reg, c_next;            // Carry flag
    logic             rd_reg, we_reg;           // Data strobes
    logic             done_reg, ack_reg;        // Event pulses
    logic [2:0]       cnt_reg, cnt_next;        // Cycle in instruction
    logic [2:0]       grp_reg;                  // Group of opcode
    logic [SP_W-1:0]  sp_reg, sp_next;          // Next free stack slot
    logic [PC_W-1:0]  stk_mem [STACK_DEPTH];    // Return stack

    ////////////////////////////////////////////////////////////////////////
    // Opcode decode
    wire logic       in_fetch = st_reg == S_FETCH;        // Opcode cycle
    wire logic       in_exec  = st_reg == S_EXEC;         // Effect cycle
    wire logic       take_int = in_fetch & int_req_i;     // Interrupt entry
    wire logic [7:0] op_w     = in_fetch ? prog_data_i : op_reg;
    wire logic [2:0] cls_w    = op_w[7:5];                // Opcode class
    wire logic       is_rel   = ~cls_w[2];
    wire logic       is_ext   = cls_w == CLS_EXT;
    wire logic       is_bit   = cls_w == CLS_BIT;
    wire logic       is_load  = cls_w == CLS_LOAD;
    wire logic       is_inh   = cls_w == CLS_INH;
    wire logic [1:0] lmode    = op_w[3:2];                // Load mode
    wire logic [1:0] bsub     = op_w[4:3];                // Bit sub-op
    wire logic       bit_test = is_bit & bsub[1];
    wire logic       ld_dir   = is_load & (lmode == LM_DIR);
    wire logic       ld_imm   = is_load & (lmode == LM_IMM);
    wire logic       ldi_reg  = ld_imm & op_w[4];
    wire logic       ld_ind   = is_load & (lmode == LM_IND);
    wire logic       ld_short = is_load & (lmode == LM_SHORT);
    // Store direction: bit 0 for indirect, bit 4 otherwise
    wire logic       ld_store = is_load & ~ld_imm
                                & (ld_ind ? op_w[0] : op_w[4]);

    // Byte count per mode
    wire logic       two_byte = is_ext | (is_bit & ~bit_test) | ld_dir
                                | (ld_imm & ~ldi_reg);
    wire logic [1:0] len_w    = two_byte ? LEN_TWO
                              : (bit_test | ldi_reg) ? LEN_THREE
                              : LEN_ONE;
    // Data operand must be read before the effect cycle
    wire logic       need_rd  = is_bit | (is_load & ~ld_imm & ~ld_store);
    // Cycles per instruction kind
    wire logic [2:0] cyc_w    = is_load  ? CYC_LDST
                              : is_rel   ? CYC_REL
                              : bit_test ? CYC_BTB
                              : is_bit   ? CYC_BIT
                              : is_ext   ? CYC_EXT
                              : CYC_INH;
    wire logic       last_w   = (cnt_reg + 3'h1) == cyc_w;
    wire logic       b2_addr  = is_bit | ldi_reg | ld_dir; // Byte 2 is addr
    // Instruction group
    wire logic [2:0] grp_w    = is_load ? GRP_LDST
                              : (is_rel | bit_test) ? GRP_BRANCH
                              : is_bit ? GRP_BITOP
                              : is_ext ? GRP_JUMP
                              : GRP_CTRL;

    ////////////////////////////////////////////////////////////////////////
    // Operands and targets
    // Accumulator is answered internally at its data address
    wire logic [7:0] rd_val  = (addr_reg == ACC_ADDR) ? acc_reg
                             : data_rdata_i;
    wire logic       rel_flg = cls_w[1] ? c_reg : z_reg;   // Tested flag
    wire logic       rel_ok  = rel_flg == cls_w[0];
    wire logic [PC_W-1:0] mag_w = {{(PC_W-4){1'b0}}, op_reg[3:0]};
    // Forward lands 1..16 ahead, backward 0..15 behind
    wire logic [PC_W-1:0] rel_tgt = op_reg[4] ? ia_reg - mag_w
                                  : ia_reg + PC_ONE + mag_w;
    wire logic [2:0] bit_num = op_reg[2:0];
    wire logic       bit_old = opnd_reg[bit_num];
    wire logic [7:0] bit_msk = 8'h01 << bit_num;
    wire logic [7:0] bit_new = bsub[0] ? (opnd_reg & ~bit_msk)
                             : (opnd_reg | bit_msk);
    wire logic       btb_ok  = bit_old == bsub[0];         // Tested sense
    wire logic [PC_W-1:0] disp_w = {{(PC_W-8){b3_reg[7]}}, b3_reg};
    wire logic [PC_W-1:0] btb_tgt = ia_reg + PC_ONE + disp_w;
    wire logic [PC_W-1:0] ext_tgt = {op_reg[3:0], b2_reg};

    ////////////////////////////////////////////////////////////////////////
    // Stack control
    wire logic do_call = in_exec & is_ext & op_reg[4];     // Call pushes
    wire logic do_ret  = in_exec & is_inh & (op_reg[4:0] == INH_RET);
    wire logic push    = do_call | take_int;
    wire logic [SP_W-1:0] sp_last = SP_W'(STACK_DEPTH - 1);
    wire logic [SP_W-1:0] sp_inc  = (sp_reg == sp_last) ? '0
                                  : sp_reg + SP_W'(1);
    wire logic [SP_W-1:0] sp_dec  = (sp_reg == '0) ? sp_last
                                  : sp_reg - SP_W'(1);
    wire logic [PC_W-1:0] stk_top = stk_mem[sp_dec];
    assign sp_next = push ? sp_inc : do_ret ? sp_dec : sp_reg;

    ////////////////////////////////////////////////////////////////////////
    // Effects of the execute cycle
    wire logic       we_exec = in_exec & ((is_bit & ~bit_test) | ld_store
                                          | ldi_reg);
    wire logic [7:0] wval    = is_bit ? bit_new
                             : ldi_reg ? b3_reg : acc_reg;
    wire logic       wr_acc  = we_exec & (addr_reg == ACC_ADDR);
    wire logic       ld_acc  = in_exec & is_load & ~ld_store & ~ldi_reg;
    wire logic [7:0] ld_val  = ld_imm ? b2_reg : opnd_reg;
    wire logic       z_upd   = in_exec & is_load & ~ldi_reg;
    assign acc_next = ld_acc ? ld_val : wr_acc ? wval : acc_reg;
    // Zero from the byte moved; immediate-to-register leaves flags
    assign z_next   = z_upd ? (ld_store ? (acc_reg == 8'h00)
                                        : (ld_val == 8'h00))
                    : z_reg;
    assign c_next   = (in_exec & is_bit) ? bit_old : c_reg;

    // Program counter selection
    wire logic byte_cyc = in_fetch | (st_reg == S_B2) | (st_reg == S_B3);
    assign pc_next = take_int ? INT_VEC
                   : byte_cyc ? pc_reg + PC_ONE
                   : ~in_exec ? pc_reg
                   : is_rel ? (rel_ok ? rel_tgt : pc_reg)
                   : bit_test ? (btb_ok ? btb_tgt : pc_reg)
                   : is_ext ? ext_tgt
                   : do_ret ? stk_top : pc_reg;

    // Data address selection
    assign addr_next =
        (in_fetch & ld_short) ? (SHORT_BASE | {6'h00, op_w[1:0]})
      : (in_fetch & ld_ind) ? (PTR_BASE | {7'h00, op_w[4]})
      : ((st_reg == S_B2) & b2_addr) ? prog_data_i
      : (st_reg == S_PTR) ? rd_val
      : addr_reg;

    ////////////////////////////////////////////////////////////////////////
    // Next state
    always_comb begin
        case (st_reg)
            S_FETCH: begin
                if (take_int)
                    st_next = S_FETCH;
                else if (len_w != LEN_ONE)
                    st_next = S_B2;
                else if (ld_ind)
                    st_next = S_PTR;
                else
                    st_next = need_rd ? S_DATA : S_EXEC;
            end
            S_B2: begin
                if (len_w == LEN_THREE)
                    st_next = S_B3;
                else
                    st_next = need_rd ? S_DATA : S_EXEC;
            end
            S_B3, S_PTR: st_next = need_rd ? S_DATA : S_EXEC;
            S_DATA:      st_next = S_EXEC;
            S_EXEC, S_PAD: st_next = last_w ? S_FETCH : S_PAD;
            default:     st_next = S_FETCH;
        endcase
    end
    assign cnt_next = (st_next == S_FETCH) ? 3'h0 : cnt_reg + 3'h1;

    ////////////////////////////////////////////////////////////////////////
    // Sequencer and program state
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            st_reg  <= S_FETCH;
            cnt_reg <= 3'h0;
            pc_reg  <= RESET_PC;
            sp_reg  <= '0;
        end else begin
            st_reg  <= st_next;
            cnt_reg <= cnt_next;
            pc_reg  <= pc_next;
            sp_reg  <= sp_next;
        end
    end

    // Instruction bytes and operand capture
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            {op_reg, b2_reg, b3_reg, opnd_reg} <= 32'h0000_0000;
            {ia_reg, grp_reg} <= {RESET_PC, GRP_CTRL};
        end else begin
            if (in_fetch & ~int_req_i) begin
                op_reg  <= prog_data_i;
                ia_reg  <= pc_reg;
                grp_reg <= grp_w;
            end
            if (st_reg == S_B2)
                b2_reg <= prog_data_i;
            if (st_reg == S_B3)
                b3_reg <= prog_data_i;
            if (st_reg == S_DATA)
                opnd_reg <= rd_val;
        end
    end

    // Data side, flags and pulses
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            {acc_reg, addr_reg, wdata_reg} <= 24'h00_0000;
            {z_reg, c_reg, rd_reg, we_reg, done_reg, ack_reg} <= 6'h00;
        end else begin
            acc_reg  <= acc_next;
            addr_reg <= addr_next;
            z_reg    <= z_next;
            c_reg    <= c_next;
            rd_reg   <= (st_next == S_PTR) | (st_next == S_DATA);
            we_reg   <= we_exec & ~wr_acc;
            done_reg <= ~in_fetch & (st_next == S_FETCH);
            ack_reg  <= take_int;
            if (we_exec)
                wdata_reg <= wval;
        end
    end

    // Return stack storage
    always_ff @(posedge clk_i) begin
        if (push)
            stk_mem[sp_reg] <= pc_reg;
    end

    assign prog_addr_o  = pc_reg;
    assign data_addr_o  = addr_reg;
    assign data_rd_o    = rd_reg;
    assign data_we_o    = we_reg;
    assign data_wdata_o = wdata_reg;
    assign acc_o        = acc_reg;
    assign zero_o       = z_reg;
    assign carry_o      = c_reg;
    assign instr_done_o = done_reg;
    assign int_ack_o    = ack_reg;
    assign grp_o        = grp_reg;

    ////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);

    chk_ldst_cycles: assert property (
        (!in_fetch && st_next == S_FETCH && is_load) |-> cnt_reg == 3'h3)
        else $error("load or store did not take four cycles");
    chk_ldi_flags: assert property (
        (in_exec && ldi_reg && addr_reg != ACC_ADDR) |=>
        (z_reg == $past(z_reg) && c_reg == $past(c_reg) && data_we_o
         && data_wdata_o == $past(b3_reg) && acc_o == $past(acc_reg)))
        else $error("immediate register load misbehaved");
    chk_bit_carry: assert property (
        (in_exec && is_bit && !bit_test) |=> carry_o == $past(bit_old))
        else $error("carry does not hold the addressed bit");
    chk_short_addr: assert property (
        (in_fetch && !int_req_i && ld_short) |=>
        data_addr_o == (SHORT_BASE | ($past(prog_data_i) & 8'h03)))
        else $error("short direct address wrong");
    chk_ind_ptr: assert property (
        (in_fetch && !int_req_i && ld_ind) |=> data_rd_o &&
        data_addr_o == (PTR_BASE | (($past(prog_data_i) >> 4) & 8'h01)))
        else $error("indirect pointer selection wrong");
    chk_rel_fwd: assert property (
        (in_exec && is_rel && rel_ok && !op_reg[4]) |=>
        prog_addr_o == $past(ia_reg) + PC_ONE + $past(mag_w))
        else $error("forward relative target wrong");
    chk_rel_fall: assert property (
        (in_exec && is_rel && !rel_ok) |=>
        prog_addr_o == $past(ia_reg) + PC_ONE)
        else $error("false branch did not fall through");
    chk_ext_target: assert property (
        (in_exec && is_ext) |=> prog_addr_o[7:0] == $past(b2_reg) &&
        {4'h0, prog_addr_o[11:8]} == ($past(op_reg) & 8'h0f))
        else $error("extended target wrong");
    chk_call_push: assert property (
        do_call |=> stk_mem[$past(sp_reg)] == $past(ia_reg) + 12'h002
        && int'(sp_reg) < STACK_DEPTH)
        else $error("call return address not stacked");
    chk_inh_one: assert property (
        (in_fetch && !int_req_i && is_inh && !int_req_i) |=>
        (st_reg == S_EXEC && prog_addr_o == $past(pc_reg) + PC_ONE)
        ##1 st_reg == S_FETCH)
        else $error("inherent instruction not one byte");

    cov_call: cover property (do_call);
    cov_btb_taken: cover property (in_exec && bit_test && btb_ok);
    cov_ldi_reg: cover property (in_exec && ldi_reg);
    cov_int_ret: cover property (take_int ##[1:40] do_ret);
endmodule
`default_nettype wire

// >>> bench/cad_mem_model.sv
// Program ROM and data RAM on the far side of the decoder
`timescale 1ns/1ps
`default_nettype none
module cad_mem_model (
    input  wire logic [cad_pkg::PC_W-1:0] prog_addr_i,  // Program address
    input  wire logic                     clk_i,        // Core clock
    input  wire logic [7:0]               data_addr_i,  // Data address
    input  wire logic                     data_rd_i,    // Read strobe
    input  wire logic                     data_we_i,    // Write pulse
    input  wire logic [7:0]               data_wdata_i, // Write byte
    output logic      [7:0]               prog_data_o,  // Program byte
    output logic      [7:0]               data_rdata_o  // Read byte
);
    import cad_pkg::*;
    logic [7:0] rom [0:4095]; // Program space, preloaded by the bench
    logic [7:0] ram [0:255];  // Data space bytes
    ////////////////////////////////////////////////////////////////////////
    // Asynchronous ROM, immediate bytes come from here
    assign prog_data_o = rom[prog_addr_i];
    // Read byte only valid while strobed, inverted otherwise
    assign data_rdata_o = data_rd_i ? ram[data_addr_i] : ~ram[data_addr_i];
    // Byte write on the one-cycle pulse; plain always so the bench may preload
    always @(posedge clk_i) begin
        if (data_we_i) begin
            ram[data_addr_i] <= data_wdata_i;
        end
    end
endmodule
`default_nettype wire

// >>> bench/tb.sv
// Self-checking bench running a short program through the decoder
`timescale 1ns/1ps
`default_nettype none
module tb;
    import cad_pkg::*;
    logic            clk_i;       // Core clock
    logic            sys_rst_i;   // Sync reset
    localparam logic [11:0] TB_VEC = 12'h200; // Interrupt target for this run
    logic            int_req_i;   // Interrupt level
    logic            ack;         // Interrupt taken pulse
    logic [PC_W-1:0] prog_addr;   // Program address
    logic [7:0]      prog_data;   // Program byte
    logic [7:0]      d_addr;      // Data address
    logic [7:0]      d_rdata;     // Data read byte
    logic [7:0]      d_wdata;     // Data write byte
    logic            d_rd;        // Read strobe
    logic            d_we;        // Write pulse
    logic [7:0]      acc;         // Accumulator
    logic            zero;        // Zero flag
    logic            carry;       // Carry flag
    logic            done;        // Instruction end
    logic [2:0]      grp;         // Group of last opcode
    logic [7:0]      v20, v30, nv; // Random data bytes
    logic [2:0]      b;           // Random bit number
    logic [7:0]      code [0:13]; // Program image from 000
    int              n_fail = 0;  // Mismatch count
    int              checks_done = 0; // Comparison count
    ////////////////////////////////////////////////////////////////////////
    cad_decoder #(.INT_VEC(TB_VEC)) uut (.clk_i(clk_i),
        .sys_rst_i(sys_rst_i),
        .prog_data_i(prog_data), .data_rdata_i(d_rdata),
        .int_req_i(int_req_i), .prog_addr_o(prog_addr),
        .data_addr_o(d_addr), .data_rd_o(d_rd), .data_we_o(d_we),
        .data_wdata_o(d_wdata), .acc_o(acc), .zero_o(zero),
        .carry_o(carry), .instr_done_o(done), .int_ack_o(ack), .grp_o(grp));
    cad_mem_model mem (.prog_addr_i(prog_addr), .clk_i(clk_i),
        .data_addr_i(d_addr), .data_rd_i(d_rd), .data_we_i(d_we),
        .data_wdata_i(d_wdata), .prog_data_o(prog_data),
        .data_rdata_o(d_rdata));
    ////////////////////////////////////////////////////////////////////////
    // Clock, 4 ns period
    initial begin
        clk_i = 1'b0;
        forever #2 clk_i = ~clk_i;
    end
    // Expected target of a one-byte relative branch
    function automatic logic [11:0] rel_tgt(logic [11:0] ia, logic [7:0] op);
        return op[4] ? ia - 12'(op[3:0]) : ia + 12'h001 + 12'(op[3:0]);
    endfunction
    // One comparison, counted
    task automatic chk(input string nm, input logic [11:0] e, g);
        checks_done++;
        if (g !== e) begin
            n_fail++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask
    // Wait for the end pulse, then check cycles, next address and group
    task automatic step(input int cyc, input logic [11:0] pc,
                        input logic [2:0] g);
        int n;
        n = 0;
        do begin
            @(posedge clk_i);
            #1;
            n++;
        end while (done !== 1'b1 && n < 20);
        chk("cycles", 12'(cyc), 12'(n));
        chk("next_pc", pc, prog_addr);
        chk("group", 12'(g), 12'(grp));
    endtask
    // Counts, verdict and end of run
    task automatic stop_test;
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////
    // Watchdog against a hung sequencer
    initial begin
        #2000;
        n_fail++;
        stop_test();
    end
    // Main sequence
    initial begin
        sys_rst_i = 1'b1;
        int_req_i = 1'b0;
        void'($urandom(16944));
        v20 = 8'($urandom);
        v30 = 8'($urandom);
        nv  = 8'($urandom);
        b   = 3'($urandom);
        for (int i = 0; i < 4096; i++) mem.rom[i] = 8'he0;
        for (int i = 0; i < 256; i++) mem.ram[i] = 8'($urandom);
        mem.ram[8'h20] = v20;
        mem.ram[8'h80] = 8'h30;
        mem.ram[8'h30] = v30;
        code = '{8'hc4, 8'h20, 8'hdc, 8'h40, nv, 8'hd1, 8'hc8,
                 8'ha0 | 8'(b), 8'h40, 8'ha8 | 8'(b), 8'h40, 8'hcc, 8'h00,
                 8'h23};
        for (int i = 0; i < 14; i++) mem.rom[i] = code[i];
        mem.rom[12'h011] = 8'h03;
        mem.rom[12'h012] = 8'h8a;
        mem.rom[12'h013] = 8'h34;
        mem.rom[12'ha34] = 8'h3f;
        mem.rom[12'ha25] = 8'h93;         // Call 300
        mem.rom[12'ha26] = 8'h00;
        mem.rom[12'h300] = 8'hb0 | 8'(b); // Branch if bit b of 40 is 0
        mem.rom[12'h301] = 8'h40;
        mem.rom[12'h302] = 8'h10;
        mem.rom[12'h311] = 8'he1;         // Return
        mem.rom[TB_VEC]  = 8'he1;         // Service routine returns at once
        repeat (8) @(posedge clk_i);
        sys_rst_i <= 1'b0;
        step(4, 12'h002, GRP_LDST);
        chk("acc", 12'(v20), 12'(acc));
        chk("zero", 12'(v20 == 8'h00), 12'(zero));
        step(4, 12'h005, GRP_LDST);
        chk("zero", 12'(v20 == 8'h00), 12'(zero));
        chk("acc", 12'(v20), 12'(acc));
        step(4, 12'h006, GRP_LDST);
        chk("ram40", 12'(nv), 12'(mem.ram[8'h40]));
        step(4, 12'h007, GRP_LDST);
        chk("acc", 12'(v30), 12'(acc));
        chk("ram81", 12'(v20), 12'(mem.ram[8'h81]));
        step(4, 12'h009, GRP_BITOP);
        chk("carry", 12'(nv[b]), 12'(carry));
        step(4, 12'h00b, GRP_BITOP);
        chk("ram40", 12'(nv | (8'h01 << b)), 12'(mem.ram[8'h40]));
        chk("carry", 12'h001, 12'(carry));
        step(4, 12'h00d, GRP_LDST);
        chk("acc", 12'h000, 12'(acc));
        chk("zero", 12'h001, 12'(zero));
        chk("carry", 12'h001, 12'(carry));
        chk("ram40", 12'(nv & ~(8'h01 << b)), 12'(mem.ram[8'h40]));
        step(2, rel_tgt(12'h00d, 8'h23), GRP_BRANCH);
        step(2, 12'h012, GRP_BRANCH);
        step(4, 12'ha34, GRP_JUMP);
        step(2, rel_tgt(12'ha34, 8'h3f), GRP_BRANCH);
        step(4, 12'h300, GRP_JUMP);
        step(5, 12'h311, GRP_BRANCH);
        chk("carry", 12'h000, 12'(carry));
        step(2, 12'ha27, GRP_CTRL);
        // Interrupt raised for the fetch that follows the no-op at a27
        @(posedge clk_i) int_req_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        int_req_i <= 1'b0;
        #1;
        chk("int_ack", 12'h001, 12'(ack));
        chk("int_pc", TB_VEC, prog_addr);
        step(2, 12'ha28, GRP_CTRL);
        stop_test();
    end
endmodule
`default_nettype wire
